// >>> lmsc_pkg.sv
// Purpose: Shared constants and types for the local memory strobe control block.
// Assumes: One memory cycle is sixteen clock periods of ref_clk.
// Notes:   Phase windows are inclusive phase numbers within a cycle.
package lmsc_pkg;

  // ----------------------------------------------------------------
  // Cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned   CLK_PERIOD_NS = 5;
  localparam int unsigned   REFRESH_NS    = 15600;
  localparam int unsigned   REFRESH_CLKS  = REFRESH_NS / CLK_PERIOD_NS;
  localparam logic [3:0]    PH_LAST       = 4'hF;
  localparam logic [3:0]    PH_ROW_END    = 4'h4;
  localparam logic [3:0]    PH_COL_BEG    = 4'h5;
  localparam logic [3:0]    PH_COL_END    = 4'h7;
  localparam logic [3:0]    PH_SEL_END    = 4'h4;
  localparam logic [3:0]    PH_RCAS_END   = 4'h2;
  localparam logic [3:0]    PH_RRAS_BEG   = 4'h1;
  localparam logic [3:0]    PH_WR_BEG     = 4'h5;
  localparam logic [3:0]    PH_WR_END     = 4'hE;
  localparam logic [3:0]    PH_DAT_BEG    = 4'h4;
  localparam logic [2:0]    CLKB_LAG      = 3'h2;

  // ----------------------------------------------------------------
  // Address map and field positions
  // ----------------------------------------------------------------
  localparam int unsigned   ADDR_W        = 21;
  localparam logic [16:0]   ID_ROM_PAGE   = 17'h00000;
  localparam logic [4:0]    ROM_SEG_LOW   = 5'h00;
  localparam logic [4:0]    ROM_SEG_HIGH  = 5'h1F;
  localparam int unsigned   ROW_LSB       = 9;
  localparam int unsigned   COL_LSB       = 1;
  localparam int unsigned   A13_BIT       = 13;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]    NET_SEL_RST   = 2'h1;
  localparam logic [7:0]    REF_ADDR_RST  = 8'h00;

  typedef enum logic [1:0] {
    LMSC_IDLE    = 2'b00,
    LMSC_ACCESS  = 2'b01,
    LMSC_REFRESH = 2'b10
  } lmsc_kind_e;

  typedef struct packed {
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [15:0]         wdata;
  } lmsc_req_s;

endpackage : lmsc_pkg

// >>> lmsc_strobe_ctrl.sv
// Purpose: Local memory bus strobe generation for DRAM, boot ROM and address ROM.
// Assumes: ref_clk is the oscillator; all inputs are synchronous to it.
// Notes:   Every output is registered, so it trails the phase counter by one edge.
//
// Functional notes
// - Output enable low on DRAM reads.
// - Output enable high for ROM reads.
// - Row address for first 5/16 cycle.
// - Row strobe low while row valid.
// - Refresh address with row strobe low.
// - Refresh indicator high during refresh cycles.
// - Bus reset low on adapter/system reset.
// - ROM select valid first 5/16, boot-in-ROM.
// - ROM select low for ROM-range reads.
// - ROM select high otherwise.
// - Later cycle part carries address bit 13.
// - Write strobe only on writes, data valid.
// - Divided clock is clock divided by eight.
// - Network selects from host bits, gated changes.
// - Column strobe 3/16; suppressed ROM; CBR refresh.
// - ID ROM enable low on its reads.
// - Two bus clocks, second lags quarter.
`timescale 1ns/1ps

module lmsc_strobe_ctrl
  import lmsc_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CLKS
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       req_valid,
  input  wire lmsc_req_s  req,
  input  wire logic       code_in_ram,
  input  wire logic       adapter_reset_bit,
  input  wire logic       system_reset_in,
  input  wire logic       clock_divide_select,
  input  wire logic [1:0] net_select_bits,
  output logic            req_taken,
  output logic [7:0]      local_addr_low,
  output logic [15:0]     local_data_out,
  output logic            local_data_oe,
  output logic            row_strobe_n,
  output logic            column_strobe_n,
  output logic            mem_output_enable_n,
  output logic            mem_write_n,
  output logic            refresh_active,
  output logic            rom_select_n,
  output logic            id_rom_enable_n,
  output logic            local_bus_reset_n,
  output logic            divided_clock_out,
  output logic            local_bus_clock_a,
  output logic            local_bus_clock_b,
  output logic            net_select_out_0,
  output logic            net_select_out_1
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (REFRESH_CYCLES < 32 || REFRESH_CYCLES > 65535) begin : g_bad_refresh
    $error("REFRESH_CYCLES must lie between 32 and 65535.");
  end

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------
  logic [3:0]  phase;
  lmsc_kind_e  kind;
  lmsc_req_s   cur;
  logic [15:0] ref_cnt;
  logic        ref_pend;
  logic [7:0]  ref_addr;
  logic        is_id;
  logic        is_rom;
  logic        rom_map;
  logic        ram_acc;
  logic        in_row;
  logic        in_col;
  logic        cyc_end;

  // Decode of the access held for the current cycle.
  assign is_id   = (cur.addr[ADDR_W-1:4] == ID_ROM_PAGE);
  assign is_rom  = !is_id && ((cur.addr[ADDR_W-1:16] == ROM_SEG_LOW) || (cur.addr[ADDR_W-1:16] == ROM_SEG_HIGH));
  assign rom_map = is_rom && !code_in_ram;
  assign ram_acc = (kind == LMSC_ACCESS) && !is_id && !rom_map;
  assign in_row  = (phase <= PH_ROW_END);
  assign in_col  = (phase >= PH_COL_BEG) && (phase <= PH_COL_END);
  assign cyc_end = (phase == PH_LAST);

  // Free-running sixteen-phase counter that frames every memory cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // Refresh timer; a pending refresh set in the taking cycle is not lost.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ref_cnt  <= 16'h0000;
      ref_pend <= 1'b0;
    end else begin
      if (ref_cnt == 16'(REFRESH_CYCLES - 1)) begin
        ref_cnt  <= 16'h0000;
        ref_pend <= 1'b1;
      end else begin
        ref_cnt <= ref_cnt + 16'h0001;
        if (cyc_end) begin
          ref_pend <= 1'b0;
        end
      end
    end
  end

  // Picks the next cycle: refresh first, then a waiting access, else idle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      kind      <= LMSC_IDLE;
      cur       <= '0;
      req_taken <= 1'b0;
    end else begin
      req_taken <= 1'b0;
      if (cyc_end) begin
        if (ref_pend) begin
          kind <= LMSC_REFRESH;
        end else if (req_valid) begin
          kind      <= LMSC_ACCESS;
          cur       <= req;
          req_taken <= 1'b1;
        end else begin
          kind <= LMSC_IDLE;
        end
      end
    end
  end

  // Refresh row address advances after each refresh cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ref_addr <= REF_ADDR_RST;
    end else if (cyc_end && kind == LMSC_REFRESH) begin
      ref_addr <= ref_addr + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Address and data pins
  // ----------------------------------------------------------------
  // Row address early, column address after, refresh address in refresh.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      local_addr_low <= 8'h00;
    end else if (kind == LMSC_REFRESH) begin
      local_addr_low <= ref_addr;
    end else if (in_row) begin
      local_addr_low <= cur.addr[ROW_LSB +: 8];
    end else begin
      local_addr_low <= cur.addr[COL_LSB +: 8];
    end
  end

  // Write data is driven on both bytes around the whole write strobe.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      local_data_out <= 16'h0000;
      local_data_oe  <= 1'b0;
    end else begin
      local_data_out <= cur.wdata;
      local_data_oe  <= (kind == LMSC_ACCESS) && cur.write && (phase >= PH_DAT_BEG);
    end
  end

  // ----------------------------------------------------------------
  // Memory strobes
  // ----------------------------------------------------------------
  // Row strobe in every access cycle and in refresh after the column strobe.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      row_strobe_n <= 1'b1;
    end else if (kind == LMSC_ACCESS) begin
      row_strobe_n <= !in_row;
    end else if (kind == LMSC_REFRESH) begin
      row_strobe_n <= !((phase >= PH_RRAS_BEG) && in_row);
    end else begin
      row_strobe_n <= 1'b1;
    end
  end
  // Column strobe for DRAM only; column-before-row in refresh.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      column_strobe_n <= 1'b1;
    end else if (kind == LMSC_REFRESH) begin
      column_strobe_n <= !(phase <= PH_RCAS_END);
    end else begin
      column_strobe_n <= !(ram_acc && in_col);
    end
  end
  // Output enable and write strobe after the row portion.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_output_enable_n <= 1'b1;
      mem_write_n         <= 1'b1;
    end else begin
      mem_output_enable_n <= !(ram_acc && !cur.write && !in_row);
      mem_write_n         <= !(ram_acc && cur.write && (phase >= PH_WR_BEG) && (phase <= PH_WR_END));
    end
  end
  // Refresh indicator spans the whole refresh cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      refresh_active <= 1'b0;
    end else begin
      refresh_active <= (kind == LMSC_REFRESH);
    end
  end
  // ROM select early in the cycle, then address bit 13 of the held access in every cycle kind.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rom_select_n <= 1'b1;
    end else if (phase <= PH_SEL_END) begin
      rom_select_n <= !((kind == LMSC_ACCESS) && rom_map && !cur.write);
    end else begin
      rom_select_n <= cur.addr[A13_BIT];
    end
  end
  // ID ROM enable for reads of its sixteen bytes, the whole cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      id_rom_enable_n <= 1'b1;
    end else begin
      id_rom_enable_n <= !((kind == LMSC_ACCESS) && is_id && !cur.write);
    end
  end

  // ----------------------------------------------------------------
  // Reset, clocks and network select
  // ----------------------------------------------------------------
  // External glue reset follows either reset source.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      local_bus_reset_n <= 1'b0;
    end else begin
      local_bus_reset_n <= !(adapter_reset_bit || system_reset_in);
    end
  end
  // Bus clocks at one eighth; the second trails by two clock periods.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      local_bus_clock_a <= 1'b0;
      local_bus_clock_b <= 1'b0;
      divided_clock_out <= 1'b0;
    end else begin
      local_bus_clock_a <= phase[2];
      local_bus_clock_b <= 3'(phase[2:0] - CLKB_LAG) >= 3'h4;
      divided_clock_out <= clock_divide_select && phase[2];
    end
  end
  // Network selects follow the host bits only while the adapter is in reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      net_select_out_0 <= NET_SEL_RST[1];
      net_select_out_1 <= NET_SEL_RST[0];
    end else if (adapter_reset_bit) begin
      net_select_out_0 <= net_select_bits[1];
      net_select_out_1 <= net_select_bits[0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_oe_ram_read;
    @(posedge ref_clk) disable iff (reset)
      ram_acc && !cur.write && !in_row |=> !mem_output_enable_n;
  endproperty
  a_oe_ram_read: assert property (p_oe_ram_read) else $error("Output enable missing on DRAM read.");
  property p_oe_rom;
    @(posedge ref_clk) disable iff (reset)
      (kind == LMSC_ACCESS) && (is_id || rom_map) |=> mem_output_enable_n;
  endproperty
  a_oe_rom: assert property (p_oe_rom) else $error("Output enable active on ROM access.");
  property p_row;
    @(posedge ref_clk) disable iff (reset)
      (kind == LMSC_ACCESS) && (phase == 4'h0) |=> !row_strobe_n [*5] ##1 row_strobe_n;
  endproperty
  a_row: assert property (p_row) else $error("Row strobe not low for five phases.");
  property p_ref_row;
    @(posedge ref_clk) disable iff (reset)
      (kind == LMSC_REFRESH) && (phase == 4'h0) |=> column_strobe_n == 1'b0 ##1 !row_strobe_n [*4];
  endproperty
  a_ref_row: assert property (p_ref_row) else $error("Refresh strobe order wrong.");
  property p_ref_ind;
    @(posedge ref_clk) disable iff (reset)
      (kind == LMSC_REFRESH) |=> refresh_active;
  endproperty
  a_ref_ind: assert property (p_ref_ind) else $error("Refresh indicator low in refresh.");
  property p_bus_reset;
    @(posedge ref_clk) disable iff (reset)
      adapter_reset_bit || system_reset_in |=> !local_bus_reset_n;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("Bus reset not asserted.");
  property p_rom_sel;
    @(posedge ref_clk) disable iff (reset)
      (kind == LMSC_ACCESS) && rom_map && !cur.write && in_row |=> !rom_select_n;
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("ROM select missing on ROM read.");
  property p_a13;
    @(posedge ref_clk) disable iff (reset)
      !in_row |=> rom_select_n == $past(cur.addr[A13_BIT]);
  endproperty
  a_a13: assert property (p_a13) else $error("Address bit 13 not on ROM select.");
  property p_write_data;
    @(posedge ref_clk) disable iff (reset)
      !mem_write_n |-> local_data_oe && refresh_active == 1'b0;
  endproperty
  a_write_data: assert property (p_write_data) else $error("Write strobe without data.");
  property p_clk_b;
    @(posedge ref_clk) disable iff (reset)
      $past(reset, 3) == 1'b0 |-> local_bus_clock_b == $past(local_bus_clock_a, 2);
  endproperty
  a_clk_b: assert property (p_clk_b) else $error("Second bus clock lag wrong.");
  property p_net_hold;
    @(posedge ref_clk) disable iff (reset)
      !adapter_reset_bit |=> $stable(net_select_out_0) && $stable(net_select_out_1);
  endproperty
  a_net_hold: assert property (p_net_hold) else $error("Network select changed outside reset.");
  c_ram_read: cover property (@(posedge ref_clk) disable iff (reset) !mem_output_enable_n);
  c_ram_write: cover property (@(posedge ref_clk) disable iff (reset) !mem_write_n);
  c_refresh: cover property (@(posedge ref_clk) disable iff (reset) refresh_active);
  c_rom_read: cover property (@(posedge ref_clk) disable iff (reset) !id_rom_enable_n);

endmodule : lmsc_strobe_ctrl

// >>> lmsc_mem_model.sv
// Purpose: Behavioural DRAM word store on the local memory bus.
// Assumes: Strobes and address are sampled on ref_clk edges.
// Notes:   Undriven read data shows the inverse of the last written word.
`timescale 1ns/1ps

module lmsc_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        column_strobe_n,
  input  wire logic        mem_write_n,
  input  wire logic        mem_output_enable_n,
  input  wire logic        refresh_active,
  input  wire logic [7:0]  local_addr_low,
  input  wire logic [15:0] local_data_out,
  input  wire logic        local_data_oe,
  output logic      [15:0] last_wr,
  output logic      [15:0] rd_data
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] mem [256];
  logic [7:0]  col     = 8'h00;
  logic        prev_cas = 1'b1;
  logic        prev_we  = 1'b1;

  initial last_wr = 16'h0000;

  // Column is latched on the column strobe fall; refresh cycles carry no column.
  always @(posedge ref_clk) begin
    prev_cas <= column_strobe_n;
    prev_we  <= mem_write_n;
    if (prev_cas && !column_strobe_n && !refresh_active) begin
      col <= local_addr_low;
    end
    if (prev_we && !mem_write_n && local_data_oe) begin
      mem[local_addr_low] <= local_data_out;
      last_wr             <= local_data_out;
    end
  end

  // The word is driven only while the output enable is low.
  assign rd_data = mem_output_enable_n ? ~last_wr : mem[col];
endmodule : lmsc_mem_model

// >>> testbench.sv
// Purpose: Self-checking bench for the local memory strobe control block.
// Assumes: Inputs change 1 ns after each rising edge of ref_clk.
// Notes:   Refresh interval is shortened to keep the run brief.
`timescale 1ns/1ps

module testbench;
  import lmsc_pkg::*;
  localparam int unsigned REF_N = 64;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid = 1'b0;
  lmsc_req_s   req = '0;
  logic        code_in_ram = 1'b0;
  logic        adapter_reset_bit = 1'b0;
  logic        system_reset_in = 1'b0;
  logic        clock_divide_select = 1'b1;
  logic [1:0]  net_select_bits = 2'h1;
  logic        req_taken, local_data_oe, row_strobe_n, column_strobe_n, mem_output_enable_n;
  logic        mem_write_n, refresh_active, rom_select_n, id_rom_enable_n, local_bus_reset_n;
  logic        divided_clock_out, local_bus_clock_a, local_bus_clock_b, net_select_out_0, net_select_out_1;
  logic [7:0]  local_addr_low, a0, a5, r0;
  logic [15:0] local_data_out, last_wr, rd_data, d10, m10;
  logic [15:0] g_ras, g_cas, g_oe, g_we, g_rs, g_id, g_rf, g_doe, g_ca, g_cb, g_dc;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;

  lmsc_strobe_ctrl #(.REFRESH_CYCLES(REF_N)) dut (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid),
    .req(req), .code_in_ram(code_in_ram), .adapter_reset_bit(adapter_reset_bit),
    .system_reset_in(system_reset_in), .clock_divide_select(clock_divide_select),
    .net_select_bits(net_select_bits), .req_taken(req_taken), .local_addr_low(local_addr_low),
    .local_data_out(local_data_out), .local_data_oe(local_data_oe), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .mem_output_enable_n(mem_output_enable_n), .mem_write_n(mem_write_n),
    .refresh_active(refresh_active), .rom_select_n(rom_select_n), .id_rom_enable_n(id_rom_enable_n),
    .local_bus_reset_n(local_bus_reset_n), .divided_clock_out(divided_clock_out),
    .local_bus_clock_a(local_bus_clock_a), .local_bus_clock_b(local_bus_clock_b),
    .net_select_out_0(net_select_out_0), .net_select_out_1(net_select_out_1));

  lmsc_mem_model mem (.ref_clk(ref_clk), .column_strobe_n(column_strobe_n), .mem_write_n(mem_write_n),
    .mem_output_enable_n(mem_output_enable_n), .refresh_active(refresh_active), .local_addr_low(local_addr_low),
    .local_data_out(local_data_out), .local_data_oe(local_data_oe), .last_wr(last_wr), .rd_data(rd_data));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  always #2.5 ref_clk = ~ref_clk;

  // A hung run is cut short and counted as a mismatch.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  function automatic logic [15:0] win(input int a, input int b);
    win = 16'h0000;
    for (int i = a; i <= b; i++) win[i] = 1'b1;
  endfunction : win

  // Records one memory cycle, one sample per phase.
  task automatic capture(input bit now);
    for (int p = 0; p < 16; p++) begin
      if (!(now && p == 0)) tick(1);
      {g_ras[p], g_cas[p], g_oe[p], g_we[p]} = {row_strobe_n, column_strobe_n, mem_output_enable_n, mem_write_n};
      {g_rs[p], g_id[p], g_rf[p], g_doe[p]} = {rom_select_n, id_rom_enable_n, refresh_active, local_data_oe};
      {g_ca[p], g_cb[p], g_dc[p]} = {local_bus_clock_a, local_bus_clock_b, divided_clock_out};
      if (p == 0) a0 = local_addr_low;
      if (p == 5) a5 = local_addr_low;
      if (p == 10) {d10, m10} = {local_data_out, rd_data};
    end
  endtask : capture

  // Kind: 0 DRAM, 1 boot ROM, 2 address ROM read, 3 write into a ROM range.
  task automatic access(input logic w, input logic [20:0] a, input logic [15:0] d, input int kind);
    req = '{write: w, addr: a, wdata: d};
    req_valid = 1'b1;
    n = 0;
    while (req_taken !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk({15'h0, req_taken}, 16'h0001);
    req_valid = 1'b0;
    capture(0);
    chk(g_ras, ~win(0, 4));
    chk(g_cas, kind == 0 ? ~win(5, 7) : 16'hFFFF);
    chk(g_oe, (kind == 0 && !w) ? ~win(5, 15) : 16'hFFFF);
    chk(g_we, (kind == 0 && w) ? ~win(5, 14) : 16'hFFFF);
    chk(g_rs, {{11{a[A13_BIT]}}, kind == 1 ? 5'h00 : 5'h1F});
    chk(g_id, kind == 2 ? 16'h0000 : 16'hFFFF);
    chk(g_rf, 16'h0000);
    chk({8'h00, a0}, {8'h00, a[16:9]});
    chk({8'h00, a5}, {8'h00, a[8:1]});
    if (kind == 0 && w) begin
      chk(g_doe, win(4, 15));
      chk(d10, d);
      chk(last_wr, d);
    end
    if (kind == 0 && !w && d != 16'h0000) chk(m10, d);
  endtask : access

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    chk({14'h0, net_select_out_0, net_select_out_1}, 16'h0001);
    chk({15'h0, local_bus_reset_n}, 16'h0000);
    reset = 1'b0;
    // Bus clocks: divide by eight, second clock two edges behind the first.
    capture(0);
    chk(16'($countones(g_ca)), 16'h0008);
    chk({8'h00, g_ca[15:8]}, {8'h00, g_ca[7:0]});
    chk({2'h0, g_cb[15:2]}, {2'h0, g_ca[13:0]});
    chk(16'($countones(g_dc)), 16'h0008);
    chk({8'h00, g_dc[15:8]}, {8'h00, g_dc[7:0]});
    clock_divide_select = 1'b0;
    tick(2);
    capture(0);
    chk(g_dc, 16'h0000);
    clock_divide_select = 1'b1;
    // Bus reset follows either reset source.
    for (int i = 0; i < 4; i++) begin
      {adapter_reset_bit, system_reset_in} = 2'(i);
      tick(3);
      chk({15'h0, local_bus_reset_n}, {15'h0, i == 0});
    end
    // Network selects load only while the adapter reset bit is set.
    adapter_reset_bit = 1'b1;
    system_reset_in = 1'b0;
    for (int i = 0; i < 4; i++) begin
      net_select_bits = 2'(i);
      tick(3);
      chk({14'h0, net_select_out_0, net_select_out_1}, 16'(i));
    end
    adapter_reset_bit = 1'b0;
    net_select_bits = 2'h0;
    tick(3);
    chk({14'h0, net_select_out_0, net_select_out_1}, 16'h0003);
    access(1'b0, 21'h052468, 16'h0000, 0);
    access(1'b1, 21'h052468, 16'hA5C3, 0);
    access(1'b0, 21'h052468, 16'hA5C3, 0);
    access(1'b0, 21'h000010, 16'h0000, 1);
    access(1'b0, 21'h00FFFE, 16'h0000, 1);
    access(1'b0, 21'h1F2000, 16'h0000, 1);
    access(1'b0, 21'h010000, 16'h0000, 0);
    access(1'b0, 21'h00000E, 16'h0000, 2);
    access(1'b0, 21'h000000, 16'h0000, 2);
    access(1'b1, 21'h1F0000, 16'h1234, 3);
    access(1'b1, 21'h000004, 16'h5678, 3);
    code_in_ram = 1'b1;
    access(1'b0, 21'h1F2000, 16'h0000, 0);
    // Two refresh cycles: timing, interval and address step.
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (refresh_active !== 1'b1 && n < REF_N + 32) begin
        tick(1);
        n++;
      end
      if (k == 1) chk(16'(n), 16'(REF_N - 16));
      capture(1);
      chk(g_rf, 16'hFFFF);
      chk(g_cas, ~win(0, 2));
      chk(g_ras, ~win(1, 4));
      chk(g_oe & g_we, 16'hFFFF);
      if (k == 1) chk({8'h00, a0}, {8'h00, r0 + 8'h01});
      r0 = a0;
      // Step past the last refresh phase so the next wait starts with the indicator low.
      tick(1);
    end
    final_report();
  end
endmodule : testbench
